// ==== src/media_mode_defs.svh ====
`ifndef MEDIA_MODE_DEFS_SVH
`define MEDIA_MODE_DEFS_SVH
// media mode field codes
`define MM_CU_ONLY      3'h0
`define MM_PASS         3'h1
`define MM_SERDES_AN    3'h2
`define MM_FX100        3'h3
`define MM_AMS_PASS     3'h5
`define MM_AMS_AN       3'h6
`define MM_AMS_FX100    3'h7
// control field positions
`define BC_UNIDIR_BIT   5
`define BC_SPD_LSB_BIT  6
`define BC_DUPLEX_BIT   8
`define BC_SPD_MSB_BIT  13
`define BS_UNIDIR_BIT   7
// reset values
`define XOVER_CTL_RST   2'h0
`define MDIX_DIS_RST    1'b0
`define DOWNSHIFT_CNT_RST 2'h1
`endif

// ==== src/media_mode_pkg.sv ====
package media_mode_pkg;
    typedef enum logic [1:0] {SPD_10, SPD_100, SPD_1000, SPD_NONE} speed_e;
    typedef enum logic [1:0] {MEDIA_CU, MEDIA_PASS, MEDIA_SERDES, MEDIA_FX} media_e;
    typedef struct packed {
        logic       an_1000_fd;
        logic       an_1000_hd;
        logic       an_100_fd;
        logic       an_100_hd;
        logic       an_10_fd;
        logic       an_10_hd;
    } ability_s;
    typedef struct packed {
        speed_e     speed;
        logic       full_duplex;
        logic       master;
        logic       valid;
    } resolve_s;
endpackage

// ==== src/pair_mapper.sv ====
`timescale 1ns/1ps
// maps four received pairs through the chosen wiring and polarity
module pair_mapper #(
    parameter int PAIRS = 4
) (
    // selection
    input  wire logic             crossed,
    input  wire logic             cd_swap,
    input  wire logic [PAIRS-1:0] invert,
    // data
    input  wire logic [PAIRS-1:0] pair_in,
    output logic      [PAIRS-1:0] pair_out
);
    logic [PAIRS-1:0] routed;

    always_comb begin
        routed = pair_in;
        if (crossed) begin
            routed[0] = pair_in[1];
            routed[1] = pair_in[0];
        end
        if (crossed ^ cd_swap) begin
            routed[2] = pair_in[3];
            routed[3] = pair_in[2];
        end
    end

    genvar g;
    generate
        for (g = 0; g < PAIRS; g++) begin : g_pol
            assign pair_out[g] = routed[g] ^ invert[g];
        end
    endgenerate
endmodule

// ==== src/phy_media_mode_control.sv ====
`timescale 1ns/1ps
`include "media_mode_defs.svh"
// Summary of operation
// - media code 001 relays fiber traffic straight between media and MAC serial
// - pass-through hides link information from standard status
// - pass-through drives link and activity LEDs, never collision, duplex, fault
// - media code 011 runs 100 Mbit fiber on media serial pins
// - 100 Mbit fiber keeps frame generator, CRC counters and loopback running
// - unidirectional enable lets fiber transmit with no valid link
// - status shows unidirectional ability bit
// - unidirectional only in fiber modes; pass-through is unidirectional always
// - two-bit field sets equalization for both serial receivers
// - negotiation off takes speed and duplex from control bits
// - non-negotiating partner gets speed by parallel detection
// - gigabit only through negotiation; forcing covers 10 and 100
// - negotiation picks best common speed, duplex and master role
// - crossover and polarity correction on after reset, two-bit control, status
// - crossover detection also when forced 10/100 if control bit clear
// - four pair mappings: straight, crossed, each with C/D swapped
// - inverted polarity corrected on every channel
// - manual field 10 forces straight, 11 crossed, 00 automatic
// - downshift drops gigabit advertisement after counted failed attempts
// - media code 010 selects serial fiber with PCS negotiation
// - codes 110, 101, 111 add auto selection to those modes
module phy_media_mode_control #(
    parameter int PAIRS = 4
) (
    // clock and reset
    input  wire logic                     ref_clk,
    input  wire logic                     sys_rst,
    // basic control and media config
    input  wire logic [2:0]               media_mode,
    input  wire logic [15:0]              basic_ctrl,
    input  wire logic                     an_enable,
    input  wire logic                     mac_an_enable,
    input  wire logic [1:0]               rx_eq_ctrl,
    input  wire logic [1:0]               xover_ctrl,
    input  wire logic                     mdix_forced_dis,
    input  wire logic [1:0]               manual_mdix,
    input  wire logic                     downshift_en,
    input  wire logic [1:0]               downshift_cnt,
    // link status inputs
    input  wire logic                     fiber_signal_present_pin,
    input  wire logic                     fiber_link_ok,
    input  wire logic                     cu_link_ok,
    input  wire logic                     partner_an_able,
    input  wire logic [1:0]               parallel_speed,
    input  media_mode_pkg::ability_s      local_adv,
    input  media_mode_pkg::ability_s      partner_adv,
    input  wire logic                     local_master_pref,
    input  wire logic                     gig_attempt_fail,
    input  wire logic                     activity,
    input  wire logic                     collision,
    input  wire logic                     an_fault,
    // twisted pair data
    input  wire logic [PAIRS-1:0]         pair_rx,
    input  wire logic [PAIRS-1:0]         pair_inverted,
    input  wire logic                     mdi_try_crossed,
    input  wire logic                     mdi_try_cd_swap,
    output logic      [PAIRS-1:0]         pair_fixed,
    // outputs
    output media_mode_pkg::media_e        media_sel,
    output logic                          passthru_relay,
    output logic                          fx100_run,
    output logic                          fiber_tx_enable,
    output logic                          std_link_status,
    output logic                          unidir_ability,
    output logic [1:0]                    eq_mac_rx,
    output logic [1:0]                    eq_media_rx,
    output logic                          fx_aux_enable,
    output media_mode_pkg::resolve_s      resolved,
    output logic                          gig_advertise,
    output logic                          downshifted,
    output logic                          mdi_crossed,
    output logic                          mdi_cd_swap,
    output logic [PAIRS-1:0]              polarity_fixed,
    output logic                          led_link,
    output logic                          led_activity,
    output logic                          led_collision,
    output logic                          led_duplex,
    output logic                          led_fault
);

    ////////////////////////////////////////////////////////////////////////
    // media mode decode

    media_mode_pkg::media_e media_r, media_nxt;
    logic ams_r, ams_nxt;

    always_comb begin
        media_nxt = media_mode_pkg::MEDIA_CU;
        unique case (media_mode)
            `MM_PASS:      media_nxt = media_mode_pkg::MEDIA_PASS;
            `MM_SERDES_AN: media_nxt = media_mode_pkg::MEDIA_SERDES;
            `MM_FX100:     media_nxt = media_mode_pkg::MEDIA_FX;
            `MM_AMS_PASS:  media_nxt = media_mode_pkg::MEDIA_PASS;
            `MM_AMS_AN:    media_nxt = media_mode_pkg::MEDIA_SERDES;
            `MM_AMS_FX100: media_nxt = media_mode_pkg::MEDIA_FX;
            default:       media_nxt = media_mode_pkg::MEDIA_CU;
        endcase
        ams_nxt = media_mode[2] && (media_nxt != media_mode_pkg::MEDIA_CU);
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            media_r <= media_mode_pkg::MEDIA_CU;
            ams_r   <= 1'b0;
        end else begin
            media_r <= media_nxt;
            ams_r   <= ams_nxt;
        end
    end

    assign media_sel = media_r;

    wire is_pass  = (media_r == media_mode_pkg::MEDIA_PASS);
    wire is_fx    = (media_r == media_mode_pkg::MEDIA_FX);
    wire is_fiber = is_fx || (media_r == media_mode_pkg::MEDIA_SERDES);

    ////////////////////////////////////////////////////////////////////////
    // fiber path, status, leds

    logic pass_r, pass_nxt, fx_r, fx_nxt, ftx_r, ftx_nxt, lnk_r, lnk_nxt;
    logic [4:0] led_r, led_nxt;

    always_comb begin
        // link only counts once the far side reports signal present
        pass_nxt = is_pass && fiber_signal_present_pin;
        fx_nxt   = is_fx;
        // pass-through is inherently one-way; others need fiber mode plus unidirectional enable or fiber link
        ftx_nxt  = is_pass || (is_fiber ? (basic_ctrl[`BC_UNIDIR_BIT] || fiber_link_ok)
                                        : 1'b0);
        if (is_pass)
            lnk_nxt = 1'b0;
        else if (is_fiber)
            lnk_nxt = fiber_link_ok;
        else
            lnk_nxt = cu_link_ok;
        led_nxt[0] = is_pass ? pass_nxt : lnk_nxt;
        led_nxt[1] = activity && led_nxt[0];
        led_nxt[2] = !is_pass && collision;
        led_nxt[3] = !is_pass && resolved.full_duplex && lnk_nxt;
        led_nxt[4] = !is_pass && an_fault;
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pass_r <= 1'b0;
            fx_r   <= 1'b0;
            ftx_r  <= 1'b0;
            lnk_r  <= 1'b0;
            led_r  <= 5'h00;
        end else begin
            pass_r <= pass_nxt;
            fx_r   <= fx_nxt;
            ftx_r  <= ftx_nxt;
            lnk_r  <= lnk_nxt;
            led_r  <= led_nxt;
        end
    end

    assign passthru_relay  = pass_r;
    assign fx100_run       = fx_r;
    assign fx_aux_enable   = fx_r;
    assign fiber_tx_enable = ftx_r;
    assign std_link_status = lnk_r;
    assign unidir_ability  = 1'b1;
    assign eq_mac_rx       = rx_eq_ctrl;
    assign eq_media_rx     = rx_eq_ctrl;
    assign {led_fault, led_duplex, led_collision, led_activity, led_link} = led_r;

    ////////////////////////////////////////////////////////////////////////
    // speed resolution

    media_mode_pkg::resolve_s res_r, res_nxt;

    always_comb begin
        res_nxt = '{speed: media_mode_pkg::SPD_NONE, full_duplex: 1'b0, master: 1'b0, valid: 1'b0};
        if (!an_enable) begin
            // gigabit code is refused when forcing; falls back to 10
            res_nxt.valid       = 1'b1;
            res_nxt.full_duplex = basic_ctrl[`BC_DUPLEX_BIT];
            res_nxt.speed = ({basic_ctrl[`BC_SPD_LSB_BIT], basic_ctrl[`BC_SPD_MSB_BIT]} == 2'h1)
                            ? media_mode_pkg::SPD_100 : media_mode_pkg::SPD_10;
        end else if (!partner_an_able) begin
            res_nxt.valid = (parallel_speed != 2'h0);
            res_nxt.speed = (parallel_speed == 2'h2) ? media_mode_pkg::SPD_100 : media_mode_pkg::SPD_10;
        end else begin
            res_nxt.valid = 1'b1;
            res_nxt.master = local_master_pref;
            if (gig_advertise && local_adv.an_1000_fd && partner_adv.an_1000_fd) begin
                res_nxt.speed = media_mode_pkg::SPD_1000;
                res_nxt.full_duplex = 1'b1;
            end else if (gig_advertise && local_adv.an_1000_hd && partner_adv.an_1000_hd) begin
                res_nxt.speed = media_mode_pkg::SPD_1000;
            end else if (local_adv.an_100_fd && partner_adv.an_100_fd) begin
                res_nxt.speed = media_mode_pkg::SPD_100;
                res_nxt.full_duplex = 1'b1;
            end else if (local_adv.an_100_hd && partner_adv.an_100_hd) begin
                res_nxt.speed = media_mode_pkg::SPD_100;
            end else if (local_adv.an_10_fd && partner_adv.an_10_fd) begin
                res_nxt.speed = media_mode_pkg::SPD_10;
                res_nxt.full_duplex = 1'b1;
            end else if (local_adv.an_10_hd && partner_adv.an_10_hd) begin
                res_nxt.speed = media_mode_pkg::SPD_10;
            end else begin
                res_nxt.valid = 1'b0;
            end
            if (res_nxt.speed != media_mode_pkg::SPD_1000)
                res_nxt.master = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst)
            res_r <= '{speed: media_mode_pkg::SPD_NONE, full_duplex: 1'b0, master: 1'b0, valid: 1'b0};
        else
            res_r <= res_nxt;
    end

    assign resolved = res_r;

    ////////////////////////////////////////////////////////////////////////
    // downshift

    logic [2:0] fail_r, fail_nxt;
    logic       ds_r, ds_nxt;

    always_comb begin
        fail_nxt = fail_r;
        ds_nxt   = ds_r;
        if (!downshift_en || cu_link_ok) begin
            fail_nxt = 3'h0;
            ds_nxt   = downshift_en && ds_r && cu_link_ok;
        end else if (gig_attempt_fail && !ds_r) begin
            fail_nxt = fail_r + 3'h1;
            // count is field value plus one attempts
            if (fail_r >= {1'b0, downshift_cnt})
                ds_nxt = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            fail_r <= 3'h0;
            ds_r   <= 1'b0;
        end else begin
            fail_r <= fail_nxt;
            ds_r   <= ds_nxt;
        end
    end

    assign downshifted   = ds_r;
    assign gig_advertise = !ds_r;

    ////////////////////////////////////////////////////////////////////////
    // crossover and polarity

    logic       xo_r, xo_nxt, sw_r, sw_nxt;
    logic [PAIRS-1:0] pol_r, pol_nxt;
    wire auto_ok = !xover_ctrl[0] && (an_enable || !mdix_forced_dis);

    always_comb begin
        xo_nxt  = xo_r;
        sw_nxt  = sw_r;
        unique case (manual_mdix)
            2'h2: begin
                xo_nxt = 1'b0;
                sw_nxt = 1'b0;
            end
            2'h3: begin
                xo_nxt = 1'b1;
                sw_nxt = 1'b0;
            end
            default: begin
                if (auto_ok) begin
                    xo_nxt = mdi_try_crossed;
                    sw_nxt = mdi_try_cd_swap;
                end else begin
                    xo_nxt = 1'b0;
                    sw_nxt = 1'b0;
                end
            end
        endcase
        // polarity correction is disabled by the upper control bit
        pol_nxt = xover_ctrl[1] ? '0 : pair_inverted;
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            xo_r  <= 1'b0;
            sw_r  <= 1'b0;
            pol_r <= '0;
        end else begin
            xo_r  <= xo_nxt;
            sw_r  <= sw_nxt;
            pol_r <= pol_nxt;
        end
    end

    assign mdi_crossed    = xo_r;
    assign mdi_cd_swap    = sw_r;
    assign polarity_fixed = pol_r;

    pair_mapper #(.PAIRS(PAIRS)) u_map (
        .crossed  (xo_r),
        .cd_swap  (sw_r),
        .invert   (pol_r),
        .pair_in  (pair_rx),
        .pair_out (pair_fixed)
    );

    ////////////////////////////////////////////////////////////////////////
    // checks
    pass_no_link_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        $past(is_pass) |-> !std_link_status) else $error("link shown in pass-through");
    pass_fiber_signal_present_pin_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        passthru_relay |-> $past(fiber_signal_present_pin)) else $error("relay without signal");
    unidir_tx_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (is_fiber && basic_ctrl[5]) |=> fiber_tx_enable) else $error("unidir tx missing");
    cu_no_tx_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (media_r == media_mode_pkg::MEDIA_CU) |=> !fiber_tx_enable) else $error("tx in copper");
    forced_speed_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !an_enable |=> resolved.speed != media_mode_pkg::SPD_1000) else $error("forced gigabit");
    force_mdi_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        manual_mdix == 2'h3 |=> mdi_crossed && !mdi_cd_swap) else $error("mdix force failed");
    ds_adv_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        downshifted |=> resolved.speed != media_mode_pkg::SPD_1000) else $error("gig after downshift");
    pass_led_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        $past(is_pass) |-> !(led_collision || led_duplex || led_fault)) else $error("bad pass led");
    fx_run_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        media_mode == 3'h3 |=> ##1 fx100_run && fx_aux_enable) else $error("fx mode not run");
    ams_code_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (media_mode[2] && media_mode[1:0] != 2'h0) |=> ams_r) else $error("auto selection lost");
endmodule

// ==== verif/link_partner_model.sv ====
`timescale 1ns/1ps
// far side of the port: fiber module and twisted-pair peer, seen as status levels
module link_partner_model (
    // clock
    input  wire logic                ref_clk,
    // status toward the port
    output logic                     fiber_signal_present_pin,
    output logic                     fiber_link_ok,
    output logic                     cu_link_ok,
    output logic                     partner_an_able,
    output logic [1:0]               parallel_speed,
    output media_mode_pkg::ability_s partner_adv,
    output logic                     gig_attempt_fail
);
    initial begin
        fiber_signal_present_pin = 1'b0;
        fiber_link_ok = 1'b0;
        cu_link_ok = 1'b0;
        partner_an_able = 1'b0;
        parallel_speed = 2'h0;
        partner_adv = 6'h00;
        gig_attempt_fail = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // signal present leads by settle cycles (none when settle is 0); a slow module lets the link follow after settle
    task automatic fiber_up(input int settle);
        @(negedge ref_clk);
        fiber_signal_present_pin = 1'b1;
        repeat (settle) @(negedge ref_clk);
        fiber_link_ok = 1'b1;
    endtask
    task automatic fiber_down();
        @(negedge ref_clk);
        fiber_signal_present_pin = 1'b0;
        fiber_link_ok = 1'b0;
    endtask
    task automatic cu_peer(input logic up, input logic able, input logic [1:0] pspd, input logic [5:0] adv);
        @(negedge ref_clk);
        cu_link_ok = up;
        partner_an_able = able;
        parallel_speed = pspd;
        partner_adv = adv;
    endtask
    // one failed gigabit attempt is a single-cycle pulse
    task automatic fail_attempt();
        @(negedge ref_clk);
        gig_attempt_fail = 1'b1;
        @(negedge ref_clk);
        gig_attempt_fail = 1'b0;
    endtask
endmodule

// ==== verif/phy_media_mode_control_test.sv ====
`timescale 1ns/1ps
module phy_media_mode_control_test;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [2:0] media_mode = 3'h0;
    logic [15:0] basic_ctrl = 16'h0100;
    logic an_enable = 1'b1, mdix_forced_dis = 1'b0, downshift_en = 1'b0, local_master_pref = 1'b1;
    logic [1:0] rx_eq_ctrl = 2'h0, xover_ctrl = 2'h0, manual_mdix = 2'h0, downshift_cnt = 2'h1;
    logic activity = 1'b1, collision = 1'b1, an_fault = 1'b1, try_x = 1'b0, try_cd = 1'b0;
    logic [3:0] pair_rx = 4'h0, pair_inverted = 4'h0;
    logic sig_present, fib_ok, cu_ok, p_able, gig_fail;
    logic [1:0] p_speed;
    media_mode_pkg::ability_s p_adv;
    media_mode_pkg::resolve_s resolved;
    media_mode_pkg::media_e media_sel;
    logic pass_relay, fx_run, tx_en, std_link, uni_ab, fx_aux, gig_adv, dshift, x_out, cd_out;
    logic led_lnk, led_act, led_col, led_dup, led_flt;
    logic [1:0] eq_mac, eq_media;
    logic [3:0] pair_fixed, pol_fixed;
    int failures = 0;
    int n_compared = 0;
    logic [5:0] adv_t [4] = '{6'h3f, 6'h14, 6'h06, 6'h01};
    logic [2:0] an_t [4] = '{3'h5, 3'h4, 3'h2, 3'h0};
    logic [15:0] ctl_t [4] = '{16'h0000, 16'h2100, 16'h0040, 16'h2140};
    logic [2:0] frc_t [4] = '{3'h0, 3'h3, 3'h0, 3'h1};
    logic [1:0] par_t [4] = '{2'h3, 2'h0, 2'h1, 2'h0};

    always #25 ref_clk = ~ref_clk;

    phy_media_mode_control dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .media_mode(media_mode),
        .basic_ctrl(basic_ctrl), .an_enable(an_enable), .mac_an_enable(1'b0), .rx_eq_ctrl(rx_eq_ctrl),
        .xover_ctrl(xover_ctrl), .mdix_forced_dis(mdix_forced_dis), .manual_mdix(manual_mdix),
        .downshift_en(downshift_en), .downshift_cnt(downshift_cnt), .fiber_signal_present_pin(sig_present),
        .fiber_link_ok(fib_ok), .cu_link_ok(cu_ok), .partner_an_able(p_able), .parallel_speed(p_speed),
        .local_adv(6'h3f), .partner_adv(p_adv), .local_master_pref(local_master_pref),
        .gig_attempt_fail(gig_fail), .activity(activity), .collision(collision), .an_fault(an_fault),
        .pair_rx(pair_rx), .pair_inverted(pair_inverted), .mdi_try_crossed(try_x), .mdi_try_cd_swap(try_cd),
        .pair_fixed(pair_fixed), .media_sel(media_sel), .passthru_relay(pass_relay), .fx100_run(fx_run),
        .fiber_tx_enable(tx_en), .std_link_status(std_link), .unidir_ability(uni_ab), .eq_mac_rx(eq_mac),
        .eq_media_rx(eq_media), .fx_aux_enable(fx_aux), .resolved(resolved), .gig_advertise(gig_adv),
        .downshifted(dshift), .mdi_crossed(x_out), .mdi_cd_swap(cd_out), .polarity_fixed(pol_fixed),
        .led_link(led_lnk), .led_activity(led_act), .led_collision(led_col), .led_duplex(led_dup),
        .led_fault(led_flt));

    link_partner_model partner (.ref_clk(ref_clk), .fiber_signal_present_pin(sig_present),
        .fiber_link_ok(fib_ok), .cu_link_ok(cu_ok), .partner_an_able(p_able), .parallel_speed(p_speed),
        .partner_adv(p_adv), .gig_attempt_fail(gig_fail));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h, expected %h", $time, seen, exp);
        end
    endtask
    // media decode is registered twice, so three edges always cover it
    task automatic settle();
        repeat (3) @(negedge ref_clk);
    endtask
    task automatic results();
        $display("failures=%0d n_compared=%0d", failures, n_compared);
        if (failures == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge ref_clk);
        failures++;
        results();
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(negedge ref_clk);
        check(media_sel, media_mode_pkg::MEDIA_CU);
        check(resolved.speed, media_mode_pkg::SPD_NONE);
        check(gig_adv, 1'b1);
        sys_rst = 1'b0;
        // fiber up, copper down: each of the eight media codes must select its own media
        partner.fiber_up(2);
        for (int i = 0; i < 8; i++) begin
            media_mode = 3'(i);
            settle();
            // enum order mirrors the low two code bits; code 100 falls back to copper
            check(media_sel, media_mode_pkg::media_e'(i[1:0]));
            check(pass_relay, i[1:0] == 2'h1);
            check(fx_run, i[1:0] == 2'h3);
            check(fx_aux, i[1:0] == 2'h3);
            check({led_lnk, led_col, led_flt}, {i[1:0] != 2'h0, i[1:0] != 2'h1, i[1:0] != 2'h1});
            if (i[1:0] == 2'h1) begin
                check(std_link, 1'b0);
                check(tx_en, 1'b1);
                check({led_act, led_col, led_dup, led_flt}, 4'h8);
            end
        end
        // unidirectional transmit with the fiber link down
        partner.fiber_down();
        media_mode = 3'h3;
        basic_ctrl = 16'h0120;
        settle();
        check(tx_en, 1'b1);
        check(uni_ab, 1'b1);
        basic_ctrl = 16'h0100;
        settle();
        check(tx_en, 1'b0);
        basic_ctrl = 16'h0120;
        media_mode = 3'h2;
        settle();
        check(tx_en, 1'b1);
        media_mode = 3'h0;
        settle();
        check(tx_en, 1'b0);
        for (int v = 0; v < 4; v++) begin
            rx_eq_ctrl = 2'(v);
            @(negedge ref_clk);
            check({eq_mac, eq_media}, {2'(v), 2'(v)});
        end
        // forced speed, then crossover detection while forced
        an_enable = 1'b0;
        partner.cu_peer(1'b1, 1'b0, 2'h0, 6'h00);
        for (int i = 0; i < 4; i++) begin
            basic_ctrl = ctl_t[i];
            settle();
            check({resolved.speed, resolved.full_duplex, resolved.valid}, {frc_t[i], 1'b1});
        end
        try_x = 1'b1;
        settle();
        check(x_out, 1'b1);
        mdix_forced_dis = 1'b1;
        settle();
        check(x_out, 1'b0);
        an_enable = 1'b1;
        for (int p = 1; p < 4; p++) begin
            partner.cu_peer(1'b1, 1'b0, 2'(p), 6'h00);
            settle();
            check(resolved.speed, par_t[p]);
        end
        for (int i = 0; i < 4; i++) begin
            local_master_pref = i[0] ? 1'b0 : 1'b1;
            partner.cu_peer(1'b1, 1'b1, 2'h0, adv_t[i]);
            settle();
            check({resolved.speed, resolved.full_duplex}, an_t[i]);
            check(led_dup, an_t[i][0]);
            if (i < 2)
                check(resolved.master, local_master_pref);
        end
        // all four pair mappings through the automatic path
        for (int k = 0; k < 4; k++) begin
            {try_cd, try_x} = 2'(k);
            settle();
            check({x_out, cd_out}, {k[0], k[1]});
        end
        {try_cd, try_x} = 2'h0;
        pair_inverted = 4'h5;
        pair_rx = 4'h3;
        settle();
        check(pol_fixed, 4'h5);
        check(pair_fixed, 4'h6);
        xover_ctrl = 2'h2;
        settle();
        check(pol_fixed, 4'h0);
        xover_ctrl = 2'h1;
        try_x = 1'b1;
        settle();
        check(x_out, 1'b0);
        xover_ctrl = 2'h0;
        manual_mdix = 2'h2;
        settle();
        check(x_out, 1'b0);
        try_x = 1'b0;
        manual_mdix = 2'h3;
        settle();
        check(x_out, 1'b1);
        // downshift after downshift_cnt+1 failed attempts, link held down
        partner.cu_peer(1'b0, 1'b1, 2'h0, 6'h3f);
        downshift_en = 1'b1;
        partner.fail_attempt();
        settle();
        check({dshift, gig_adv}, 2'h1);
        partner.fail_attempt();
        settle();
        check({dshift, gig_adv}, 2'h2);
        check({resolved.speed, resolved.full_duplex}, 3'h3);
        downshift_en = 1'b0;
        settle();
        check({dshift, gig_adv}, 2'h1);
        results();
    end
endmodule
